// [baud_pkg.sv]
package baud_pkg;

  // ****************************************************************
  // Register map, byte addresses on the APB word grid.
  // ****************************************************************
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;  // Rate and clock select.
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;  // Echo and interrupt bits.
  localparam logic [7:0] DATA_OFFSET = 8'h08;     // Receive data; writes are ignored.
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;   // Block state.

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int RATE_LSB = 0;          // Divisor code, bits 3..0.
  localparam int CLKSRC_BIT = 4;        // Transmitter uses receiver tick; receive clock pin only at code zero.
  localparam int ECHO_BIT = 4;          // Echo mode in command register.
  localparam int TXIRQ_LSB = 2;         // Transmit interrupt field 3..2.
  localparam int RXIRQ_BIT = 1;         // Receive interrupt enable (0 off).
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [1:0] TXIRQ_OFF = 2'h2;  // Code 10 disables tx irq.

  // ****************************************************************
  // Timing: external clock mode runs sixteen clocks per bit.
  // ****************************************************************
  localparam logic [15:0] EXT_DIVISOR = 16'h0010;
  localparam int OVERSAMPLE = 16;

  // Signals of one APB request travel together.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_type;

  // Divisor table indexed by the four-bit rate code.
  function automatic logic [15:0] divisor_of(input logic [3:0] code);
    logic [15:0] d;
    d = EXT_DIVISOR;
    case (code)
      4'h1: d = 16'd36864;
      4'h2: d = 16'd24576;
      4'h3: d = 16'd16768;
      4'h4: d = 16'd13696;
      4'h5: d = 16'd12288;
      4'h6: d = 16'd6144;
      4'h7: d = 16'd3072;
      4'h8: d = 16'd1536;
      4'h9: d = 16'd1024;
      4'ha: d = 16'd768;
      4'hb: d = 16'd512;
      4'hc: d = 16'd384;
      4'hd: d = 16'd256;
      4'he: d = 16'd192;
      4'hf: d = 16'd96;
      default: d = EXT_DIVISOR;
    endcase
    return d;
  endfunction

endpackage

// [rate_divider.sv]
`timescale 1ns/100ps
`default_nettype none

// ******************************************************************
// Pulse divider: one enable pulse every "divisor" input ticks.
// ******************************************************************
module rate_divider #(
  parameter int WIDTH = 16  // Counter width.
) (
  input wire logic clk_sys,              // System clock.
  input wire logic reset_n,              // Asynchronous reset, low.
  input wire logic tick,                 // Input tick to be divided.
  input wire logic [WIDTH-1:0] divisor,  // Ticks per output pulse.
  output logic pulse                     // One-cycle output pulse.
);

  initial begin
    if (WIDTH < 8) $error("rate_divider WIDTH too small");
  end

  // All state sits in one struct.
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic pulse;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Count ticks; a shrinking divisor is caught by the >= test.
  always_comb begin
    state_next = state_reg;
    state_next.pulse = 1'b0;
    if (tick) begin
      if (state_reg.count >= divisor - 1'b1) begin
        state_next.count = '0;
        state_next.pulse = 1'b1;
      end else begin
        state_next.count = state_reg.count + 1'b1;
      end
    end
  end

  // Register the state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pulse = state_reg.pulse;

endmodule

`default_nettype wire

// [echo_fifo.sv]
`timescale 1ns/100ps
`default_nettype none

// ******************************************************************
// Small flip-flop FIFO with valid/ready on both sides.
// ******************************************************************
module echo_fifo #(
  parameter int WIDTH = 8,  // Word width.
  parameter int DEPTH = 4   // Number of words.
) (
  input wire logic clk_sys,            // System clock.
  input wire logic reset_n,            // Asynchronous reset, low.
  input wire logic inValid,            // Writer offers a word.
  output logic inReady,                // Room for a word.
  input wire logic [WIDTH-1:0] inData, // Word written.
  output logic outValid,               // A word is waiting.
  input wire logic outReady,           // Reader takes the word.
  output logic [WIDTH-1:0] outData     // Oldest word.
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be pow2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit.
  assign full = (state_reg.wrPtr[AW] != state_reg.rdPtr[AW]) &&
                (state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]);
  assign empty = (state_reg.wrPtr == state_reg.rdPtr);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = state_reg.mem[state_reg.rdPtr[AW-1:0]];

  // Push and pop; both may occur in one cycle.
  always_comb begin
    state_next = state_reg;
    if (inValid && !full) begin
      state_next.mem[state_reg.wrPtr[AW-1:0]] = inData;
      state_next.wrPtr = state_reg.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      state_next.rdPtr = state_reg.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// [serial_adapter.sv]
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Codes 1-7 pick divisors 36864 down to 3072
// - Codes 8-15 pick divisors 1536 down to 96
// - Bit rate is oscillator over selected divisor
// - Code zero: bit rate external clock /16
// - External receive clock: sample at one sixteenth
// - Echo retransmits each received character immediately
// - Command bits 3:2 = 10 disable tx interrupts
// - Command bit 1 zero disables rx interrupts
// - Echo mode forces request-to-send low
// - Divisor comes from control bits 3..0

module serial_adapter #(
  parameter int FIFO_DEPTH = 4  // Echo buffer depth.
) (
  input wire logic clk_sys,             // System clock, 50 MHz.
  input wire logic reset_n,             // Asynchronous reset, low.
  input wire logic psel,                // APB select.
  input wire logic penable,             // APB enable.
  input wire logic pwrite,              // APB direction.
  input wire logic [7:0] paddr,         // APB byte address.
  input wire logic [31:0] pwdata,       // APB write data.
  output logic [31:0] prdata,           // APB read data.
  output logic pready,                  // APB ready.
  output logic pslverr,                 // APB error.
  input wire logic crystal_clock_in,    // Oscillator/external clock pin.
  input wire logic receive_clock,       // External receive clock pin.
  input wire logic rxd,                 // Serial data in.
  output logic txd,                     // Serial data out.
  output logic rts_n,                   // Request to send, low active.
  output logic txIrqEnable,             // Transmit interrupts allowed.
  output logic rxIrqEnable              // Receive interrupts allowed.
);

  // ****************************************************************
  // Types and state.
  // ****************************************************************
  typedef enum logic [1:0] {IDLE, DATA, STOP} phase_type;

  typedef struct packed {
    logic [7:0] control;         // Rate code and clock source.
    logic [7:0] command;         // Echo and interrupt fields.
    logic [2:0] xtalSync;        // Oscillator pin synchroniser.
    logic [2:0] rclkSync;        // Receive clock pin synchroniser.
    logic [2:0] rxdSync;         // Data pin synchroniser.
    logic rxLevel;               // Filtered data level.
    phase_type rxPhase;          // Receiver phase.
    logic [3:0] rxSub;           // Sixteenth-bit counter.
    logic [2:0] rxBit;           // Receive bit index.
    logic [7:0] rxShift;         // Receive shift register.
    logic [7:0] rxData;          // Last received character.
    logic rxFull;                // Receive data waiting.
    logic rxPush;                // Echo push request.
    phase_type txPhase;          // Transmitter phase.
    logic [3:0] txSub;           // Sixteenth-bit counter.
    logic [2:0] txBit;           // Transmit bit index.
    logic [7:0] txShift;         // Transmit shift register.
    logic txd;                   // Line level.
    logic echoDrop;              // Echo character lost.
    logic [31:0] rdata;          // Registered read data.
  } state_type;

  state_type state_reg;
  state_type state_next;

  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  // ****************************************************************
  // Pin edges: a rise counts when stage two is high and stage three still low.
  // ****************************************************************
  logic xtalRise;
  logic rclkRise;
  assign xtalRise = state_reg.xtalSync[1] && !state_reg.xtalSync[2];
  assign rclkRise = state_reg.rclkSync[1] && !state_reg.rclkSync[2];

  // ****************************************************************
  // Rate generation.
  // ****************************************************************
  logic [3:0] rateCode;
  logic [15:0] divisor;
  logic [15:0] bitDivisor;
  logic bitTick;
  logic txTick;
  logic rxTick;

  assign rateCode = state_reg.control[baud_pkg::RATE_LSB +: 4];
  assign divisor = baud_pkg::divisor_of(rateCode);

  // The divider yields sixteen ticks per bit, so it divides by the
  // table value over sixteen; code zero divides by one.
  assign bitDivisor = (rateCode == 4'h0) ? 16'h0001 :
                      (divisor >> 4);

  rate_divider #(
    .WIDTH(16)
  ) u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick(xtalRise),
    .divisor(bitDivisor),
    .pulse(bitTick)
  );

  // Receiver runs on the external receive clock when code zero and
  // the clock source bit say so; transmitter may share it.
  assign rxTick = (rateCode == 4'h0 &&
                   state_reg.control[baud_pkg::CLKSRC_BIT]) ?
                  rclkRise : bitTick;
  assign txTick = state_reg.control[baud_pkg::CLKSRC_BIT] ? rxTick :
                  bitTick;

  // ****************************************************************
  // Echo buffer between receiver and transmitter.
  // ****************************************************************
  logic echoMode;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic txLoad;

  assign echoMode = state_reg.command[baud_pkg::ECHO_BIT];
  assign txLoad = (state_reg.txPhase == IDLE) && fifoOutValid;

  echo_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inValid(state_reg.rxPush),
    .inReady(fifoInReady),
    .inData(state_reg.rxData),
    .outValid(fifoOutValid),
    .outReady(txLoad),
    .outData(fifoOutData)
  );

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  logic access;
  logic mapped;
  assign access = psel && penable;
  assign mapped = (paddr == baud_pkg::CONTROL_OFFSET) ||
                  (paddr == baud_pkg::COMMAND_OFFSET) ||
                  (paddr == baud_pkg::DATA_OFFSET) ||
                  (paddr == baud_pkg::STATUS_OFFSET);

  // ****************************************************************
  // Next-state logic for registers, receiver and transmitter.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rxPush = 1'b0;
    state_next.xtalSync = {state_reg.xtalSync[1:0], crystal_clock_in};
    state_next.rclkSync = {state_reg.rclkSync[1:0], receive_clock};
    state_next.rxdSync = {state_reg.rxdSync[1:0], rxd};
    // Data level only moves when the later stages agree.
    if (state_reg.rxdSync[1] == state_reg.rxdSync[2]) begin
      state_next.rxLevel = state_reg.rxdSync[2];
    end

    // Register writes; reads return the registered word.
    if (psel && !penable) begin
      case (paddr)
        baud_pkg::CONTROL_OFFSET:
          state_next.rdata = {24'h0, state_reg.control};
        baud_pkg::COMMAND_OFFSET:
          state_next.rdata = {24'h0, state_reg.command};
        baud_pkg::DATA_OFFSET:
          state_next.rdata = {24'h0, state_reg.rxData};
        baud_pkg::STATUS_OFFSET:
          state_next.rdata = {29'h0, state_reg.echoDrop, fifoOutValid,
                              state_reg.rxFull};
        default: state_next.rdata = 32'h0;
      endcase
    end
    if (access && pwrite && mapped) begin
      if (paddr == baud_pkg::CONTROL_OFFSET) begin
        state_next.control = pwdata[7:0];
      end else if (paddr == baud_pkg::COMMAND_OFFSET) begin
        state_next.command = pwdata[7:0];
      end else if (paddr == baud_pkg::STATUS_OFFSET) begin
        state_next.echoDrop = 1'b0;
      end
    end
    if (access && !pwrite && paddr == baud_pkg::DATA_OFFSET) begin
      state_next.rxFull = 1'b0;
    end

    // Receiver: sixteen ticks per bit, sampled mid-bit.
    if (rxTick) begin
      case (state_reg.rxPhase)
        IDLE: begin
          if (!state_reg.rxLevel) begin
            state_next.rxSub = state_reg.rxSub + 4'h1;
            if (state_reg.rxSub == 4'h7) begin
              state_next.rxSub = 4'h0;
              state_next.rxBit = 3'h0;
              state_next.rxPhase = DATA;
            end
          end else begin
            state_next.rxSub = 4'h0;  // False start is dropped.
          end
        end
        DATA: begin
          state_next.rxSub = state_reg.rxSub + 4'h1;
          if (state_reg.rxSub == 4'hf) begin
            state_next.rxShift = {state_reg.rxLevel,
                                  state_reg.rxShift[7:1]};
            state_next.rxBit = state_reg.rxBit + 3'h1;
            if (state_reg.rxBit == 3'h7) begin
              state_next.rxPhase = STOP;
            end
          end
        end
        STOP: begin
          state_next.rxSub = state_reg.rxSub + 4'h1;
          if (state_reg.rxSub == 4'hf) begin
            state_next.rxSub = 4'h0;
            state_next.rxPhase = IDLE;
            if (state_reg.rxLevel) begin
              state_next.rxData = state_reg.rxShift;
              state_next.rxFull = 1'b1;  // Set wins over read clear.
              // In echo mode every good character goes straight to the echo path.
              if (echoMode) begin
                state_next.rxPush = 1'b1;
              end
            end
          end
        end
        default: state_next.rxPhase = IDLE;
      endcase
    end
    // A full buffer loses the character and flags it.
    if (state_reg.rxPush && !fifoInReady) begin
      state_next.echoDrop = 1'b1;
    end

    // Transmitter: start, eight data bits, one stop bit.
    if (txLoad) begin
      state_next.txShift = fifoOutData;
      state_next.txPhase = DATA;
      state_next.txBit = 3'h0;
      state_next.txSub = 4'h0;
      state_next.txd = 1'b0;
    end else if (txTick && state_reg.txPhase != IDLE) begin
      state_next.txSub = state_reg.txSub + 4'h1;
      if (state_reg.txSub == 4'hf) begin
        case (state_reg.txPhase)
          DATA: begin
            state_next.txd = state_reg.txShift[0];
            state_next.txShift = {1'b1, state_reg.txShift[7:1]};
            state_next.txBit = state_reg.txBit + 3'h1;
            if (state_reg.txBit == 3'h7) begin
              state_next.txPhase = STOP;
            end
          end
          STOP: begin
            // Last data bit ends, then a full stop bit at mark.
            state_next.txd = 1'b1;
            state_next.txBit = 3'h1;
            if (state_reg.txBit != 3'h0) begin
              state_next.txPhase = IDLE;
            end
          end
          default: state_next.txPhase = IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.control <= baud_pkg::CONTROL_RESET;
      state_reg.command <= baud_pkg::COMMAND_RESET;
      state_reg.xtalSync <= 3'h0;
      state_reg.rxdSync <= 3'h7;
      state_reg.rxLevel <= 1'b1;
      state_reg.txd <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign txd = state_reg.txd;
  // Echo mode drives request-to-send active.
  assign rts_n = !echoMode;
  // Code 10 on bits 3:2 shuts transmit interrupts off.
  assign txIrqEnable = (state_reg.command[baud_pkg::TXIRQ_LSB +: 2] !=
                        baud_pkg::TXIRQ_OFF);
  // A zero in bit 1 shuts receive interrupts off.
  assign rxIrqEnable = state_reg.command[baud_pkg::RXIRQ_BIT];
  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

endmodule

`default_nettype wire

// [serial_adapter_chk.sv]
`timescale 1ns/100ps
`default_nettype none

// ******************
// Port checker.
// ******************
module serial_adapter_chk (
  input wire logic clk_sys, // System clock.
  input wire logic reset_n, // Reset, low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic crystal_clock_in, // Oscillator pin.
  input wire logic receive_clock, // Receive clock pin.
  input wire logic rxd, // Serial in.
  input wire logic txd, // Serial out.
  input wire logic rts_n, // Request to send.
  input wire logic txIrqEnable, // Tx interrupts on.
  input wire logic rxIrqEnable // Rx interrupts on.
);
  // Pacing edges per bit for each rate code.
  localparam int DIV [16] = '{16, 36864, 24576, 16768, 13696, 12288,
    6144, 3072, 1536, 1024, 768, 512, 384, 256, 192, 96};
  logic [7:0] ctlReg; // Shadow of the control register.
  logic [7:0] cmdReg; // Shadow of the command register.
  logic [31:0] lowCnt; // Pacing edges seen while txd is low.
  logic lk; // Clock that paces the transmitter.
  logic lkPrev; // Its level one cycle ago.
  logic wr; // A write lands at this edge.

  assign wr = psel && penable && pwrite;
  // Code zero with bit 4 puts both directions on the receive clock.
  assign lk = (ctlReg[3:0] == 4'h0 && ctlReg[4]) ? receive_clock :
    crystal_clock_in;

  // Low runs of txd are counted in pacing edges.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctlReg <= baud_pkg::CONTROL_RESET;
      cmdReg <= baud_pkg::COMMAND_RESET;
      lkPrev <= 1'b0;
      lowCnt <= '0;
    end else begin
      lkPrev <= lk;
      if (wr && paddr == baud_pkg::CONTROL_OFFSET) begin
        ctlReg <= pwdata[7:0];
      end
      if (wr && paddr == baud_pkg::COMMAND_OFFSET) begin
        cmdReg <= pwdata[7:0];
      end
      if (txd) begin
        lowCnt <= '0;
      end else if (lk && !lkPrev) begin
        lowCnt <= lowCnt + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_rts; rts_n == !cmdReg[baud_pkg::ECHO_BIT]; endproperty
  a_rts: assert property (p_rts) else $error("rts_n wrong");
  property p_txirq;
    txIrqEnable == (cmdReg[3:2] != baud_pkg::TXIRQ_OFF);
  endproperty
  a_txirq: assert property (p_txirq) else $error("tx irq wrong");
  property p_rxirq; rxIrqEnable == cmdReg[1]; endproperty
  a_rxirq: assert property (p_rxirq) else $error("rx irq wrong");
  property p_bitlen;
    $rose(txd) |-> lowCnt != 0 && lowCnt % DIV[ctlReg[3:0]] == 0;
  endproperty
  a_bitlen: assert property (p_bitlen) else $error("bit length");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_slverr;
    psel && penable && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > baud_pkg::STATUS_OFFSET);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slave error");
  property p_rdcmd;
    psel && penable && !pwrite && paddr == baud_pkg::COMMAND_OFFSET |->
      prdata == {24'h0, cmdReg};
  endproperty
  a_rdcmd: assert property (p_rdcmd) else $error("command read");
  property p_rdctl;
    psel && penable && !pwrite && paddr == baud_pkg::CONTROL_OFFSET |->
      prdata == {24'h0, ctlReg};
  endproperty
  a_rdctl: assert property (p_rdctl) else $error("control read");

  c_echo: cover property ($rose(txd) && cmdReg[4]);
  c_err: cover property (pslverr && penable);
  c_fast: cover property ($rose(txd) && ctlReg[3:0] == 4'hf);
endmodule

bind serial_adapter serial_adapter_chk u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .crystal_clock_in(crystal_clock_in),
  .receive_clock(receive_clock), .rxd(rxd), .txd(txd), .rts_n(rts_n),
  .txIrqEnable(txIrqEnable), .rxIrqEnable(rxIrqEnable));

`default_nettype wire

// [modem_link_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ******************
// Far-end modem.
// ******************
module modem_link_model (
  input wire logic bitClk, // Edges that pace each bit.
  input wire logic [15:0] bitEdges, // Pacing edges per bit.
  input wire logic localLoop, // High loops txd back.
  input wire logic txd, // Adapter serial output.
  output logic rxd, // Line into the adapter.
  output logic [15:0] heard, // Last two characters seen.
  output logic [7:0] heardCount // Characters seen.
);
  logic lineOut = 1'b1; // Far line, idles at mark.

  // The external mux cuts the far line off and loops txd back.
  assign rxd = localLoop ? txd : lineOut;

  task automatic waitEdges(input int n);
    repeat (n) @(posedge bitClk);
  endtask

  // One 8N1 character, least significant bit first.
  task automatic send(input logic [7:0] b);
    lineOut = 1'b0;
    waitEdges(bitEdges);
    for (int i = 0; i < 8; i++) begin
      lineOut = b[i];
      waitEdges(bitEdges);
    end
    lineOut = 1'b1;
    waitEdges(bitEdges);
  endtask

  // Samples mid-bit; a character with a low stop bit is dropped.
  initial begin
    logic [7:0] b;
    heard = 16'h0;
    heardCount = 8'h0;
    forever begin
      @(negedge txd);
      waitEdges(bitEdges / 2);
      for (int i = 0; i < 8; i++) begin
        waitEdges(bitEdges);
        b[i] = txd;
      end
      waitEdges(bitEdges);
      if (txd) begin
        heard = {heard[7:0], b};
        heardCount = heardCount + 8'h1;
      end
    end
  end
endmodule

`default_nettype wire

// [serial_adapter_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module serial_adapter_tb;
  // Command value beside expected {rts_n, txIrqEnable, rxIrqEnable}.
  localparam logic [10:0] ROWS [6] = '{{8'h00, 3'b110}, {8'h02, 3'b111},
    {8'h08, 3'b100}, {8'h0c, 3'b110}, {8'h12, 3'b011}, {8'h1a, 3'b001}};
  logic clk_sys = 1'b0; // System clock.
  logic reset_n = 1'b0; // Reset, low.
  baud_pkg::apb_req_type req = '0; // APB request.
  logic [31:0] prdata; // APB read data.
  logic pready; // APB ready.
  logic pslverr; // APB error.
  logic crystalClock = 1'b0; // Oscillator pin.
  logic receiveClock = 1'b0; // Receive clock pin.
  logic linkSel = 1'b0; // Modem paced by receive clock.
  logic linkClk; // Clock pacing the modem.
  logic [15:0] bitEdges = 16'd16; // Modem edges per bit.
  logic localLoop = 1'b0; // Local loop select.
  logic rxd, txd, rts_n, txIrqEnable, rxIrqEnable; // Serial side.
  logic [15:0] heard; // Characters echoed back.
  logic [7:0] heardCount; // Count of them.
  logic [31:0] r; // Last read data.
  logic e; // Last error flag.
  int badCount = 0;
  int checkCount = 0;

  always #10 clk_sys = ~clk_sys;
  // Pins toggle well below a quarter of the system clock.
  always begin
    repeat (3) @(posedge clk_sys);
    crystalClock <= ~crystalClock;
  end
  always begin
    repeat (5) @(posedge clk_sys);
    receiveClock <= ~receiveClock;
  end
  assign linkClk = linkSel ? receiveClock : crystalClock;

  serial_adapter #(.FIFO_DEPTH(4)) u_serial_adapter (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(req.sel), .penable(req.enable),
    .pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock_in(crystalClock), .receive_clock(receiveClock),
    .rxd(rxd), .txd(txd), .rts_n(rts_n), .txIrqEnable(txIrqEnable),
    .rxIrqEnable(rxIrqEnable));
  modem_link_model u_modem_link_model (.bitClk(linkClk),
    .bitEdges(bitEdges), .localLoop(localLoop), .txd(txd), .rxd(rxd),
    .heard(heard), .heardCount(heardCount));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: d};
    @(posedge clk_sys);
    req.enable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    req.sel <= 1'b0;
    req.enable <= 1'b0;
  endtask

  task automatic waitHeard(input logic [7:0] n);
    repeat (20000) begin
      @(posedge clk_sys);
      if (heardCount == n) break;
    end
  endtask

  task automatic results;
    if (badCount == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Nearly three times the expected run means a hang.
  initial begin
    #1200000;
    badCount++;
    results;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk({28'h0, txd, rts_n, txIrqEnable, rxIrqEnable}, 32'he);
    chk({prdata[31:1], pslverr}, 32'h0);
    apb(1'b0, baud_pkg::CONTROL_OFFSET, 32'h0);
    chk(r, {24'h0, baud_pkg::CONTROL_RESET});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, baud_pkg::COMMAND_OFFSET, {24'h0, ROWS[i][10:3]});
      apb(1'b0, baud_pkg::COMMAND_OFFSET, 32'h0);
      chk(r, {24'h0, ROWS[i][10:3]});
      chk({29'h0, rts_n, txIrqEnable, rxIrqEnable}, {29'h0, ROWS[i][2:0]});
    end
    // An unmapped word refuses both directions.
    apb(1'b1, 8'h10, 32'hff);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({r[31:1], e}, 32'h1);
    // Remote loop-back paced by the receive clock.
    linkSel <= 1'b1;
    apb(1'b1, baud_pkg::CONTROL_OFFSET, 32'h10);
    apb(1'b1, baud_pkg::COMMAND_OFFSET, 32'h19);
    u_modem_link_model.send(8'ha5);
    u_modem_link_model.send(8'h3c);
    waitHeard(8'h2);
    chk({16'h0, heard}, 32'ha53c);
    // Fastest divided rate from the oscillator.
    linkSel <= 1'b0;
    bitEdges <= 16'd96;
    apb(1'b1, baud_pkg::CONTROL_OFFSET, 32'h1f);
    u_modem_link_model.send(8'h5a);
    waitHeard(8'h3);
    chk({16'h0, heard}, 32'h3c5a);
    chk({24'h0, heardCount}, 32'h3);
    apb(1'b0, baud_pkg::STATUS_OFFSET, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, baud_pkg::DATA_OFFSET, 32'h0);
    chk(r, 32'h5a);
    // Local loop-back cuts the far line off.
    localLoop <= 1'b1;
    u_modem_link_model.send(8'hc3);
    repeat (600) @(posedge clk_sys);
    chk({24'h0, heardCount}, 32'h3);
    apb(1'b0, baud_pkg::STATUS_OFFSET, 32'h0);
    chk({31'h0, r[0]}, 32'h0);
    chk({31'h0, txd}, 32'h1);
    localLoop <= 1'b0;
    // A second reset in mid-run restores the idle state.
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    chk({28'h0, txd, rts_n, txIrqEnable, rxIrqEnable}, 32'he);
    reset_n <= 1'b1;
    apb(1'b0, baud_pkg::COMMAND_OFFSET, 32'h0);
    chk(r, 32'h0);
    results;
  end
endmodule

`default_nettype wire
